// ===== src/byte_fifo.sv
// Byte buffer with count, full/empty and error pulses.
// Assumes push and pop come from logic on the same clock; DEPTH a power of two.
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Drain side
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    // Level and errors
    output logic [$clog2(DEPTH):0] count,
    output logic full,
    output logic empty,
    output logic overflow,
    output logic underflow
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] next_count;
    logic do_push, do_pop;

    assign full = (count == CW'(DEPTH));
    assign empty = (count == '0);
    assign do_pop = pop && !empty;
    assign do_push = push && (!full || do_pop);
    assign overflow = push && !do_push;
    assign underflow = pop && empty;
    assign head = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = do_push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = do_pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = CW'(count + 1'b1);
        end else if (do_pop && !do_push) begin
            next_count = CW'(count - 1'b1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge pclk) begin
            if (do_push && wr_ptr == AW'(g)) begin
                mem[g] <= push_data;
            end
        end
    end

    a_count_track: assert property (@(posedge pclk) disable iff (!presetn)
        count == CW'($past(count) + CW'($past(do_push)) - CW'($past(do_pop))))
        else $error("buffer count does not follow push and pop");
    a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
        (full && push && !pop) |=> (count == CW'(DEPTH)) && $stable(wr_ptr))
        else $error("push into full buffer changed it");
endmodule

// ===== src/fifo_pair_pkg.sv
// Constants, register map and codes for the radio data buffer pair.
// Assumes a 200 MHz pclk, an APB master and an SPI master sampled on pclk.
// ----------------------------------------------------------------------------
// Behaviour
// - Two separate 64-entry byte buffers, receive and transmit.
// - Host reads receive, writes transmit; one byte each.
// - Flag receive overflow and transmit underflow.
// - Status byte during header carries fill level.
// - Both byte counts readable at any time.
// - One 4-bit selector sets both thresholds.
// - Receive threshold 4*(v+1), transmit 61-4*v.
// - Threshold signal high while count reaches threshold.
// - Codes 0x00/0x02 route thresholds to output pins.
// ----------------------------------------------------------------------------
package fifo_pair_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 64;
    localparam int NUM_PINS = 3;
    localparam int COUNT_W = 7;
    localparam int THR_W = 4;
    localparam int SEL_W = 6;
    localparam int SEL_STRIDE = 8;
    localparam int IRQ_W = 2;
    // Register byte offsets
    localparam logic [11:0] OFF_THR = 12'h000;
    localparam logic [11:0] OFF_PIN_SEL = 12'h004;
    localparam logic [11:0] OFF_RX_COUNT = 12'h008;
    localparam logic [11:0] OFF_TX_COUNT = 12'h00C;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
    // Field positions
    localparam int IRQ_RX_OVF = 0;
    localparam int IRQ_TX_UNF = 1;
    localparam int HDR_READ_BIT = 7;
    // Reset values
    localparam logic [3:0] THR_RST = 4'h7;
    localparam logic [5:0] PIN_SEL_RST = 6'h00;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    // Pin signal codes and threshold coding
    localparam logic [5:0] SEL_RX_THR = 6'h00;
    localparam logic [5:0] SEL_TX_THR = 6'h02;
    localparam int THR_STEP = 4;
    localparam int TX_THR_BASE = 61;
    localparam int THR_SUM = 65;
    // Header address that selects the buffers
    localparam logic [5:0] FIFO_ADDR = 6'h3F;
endpackage

// ===== src/radio_data_fifo_pair.sv
// Receive/transmit data buffer pair with SPI access, APB registers and pins.
// Assumes SPI mode 0 from an external master, packet engine on pclk.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module radio_data_fifo_pair #(
    parameter int DEPTH = fifo_pair_pkg::FIFO_DEPTH,
    parameter int PINS = fifo_pair_pkg::NUM_PINS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // SPI slave pins
    input wire logic spi_csn_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Packet engine
    input wire logic rx_push,
    input wire logic [7:0] rx_push_data,
    input wire logic tx_pop,
    output logic [7:0] tx_pop_data,
    // Pins and interrupt
    output logic [PINS-1:0] general_output_pin,
    output logic irq
);
    localparam int CW = fifo_pair_pkg::COUNT_W;
    localparam int IW = fifo_pair_pkg::IRQ_W;

    // ----------------------------------------
    // Buffers
    // ----------------------------------------
    logic [CW-1:0] rx_byte_count, tx_byte_count;
    logic [7:0] rx_head, tx_head, spi_tx_data;
    logic spi_rx_pop, spi_tx_push, rx_overflow, tx_underflow, tx_empty;

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
        .pclk(pclk), .presetn(presetn),
        .push(rx_push), .push_data(rx_push_data),
        .pop(spi_rx_pop), .head(rx_head),
        .count(rx_byte_count), .full(), .empty(),
        .overflow(rx_overflow), .underflow()
    );

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .pclk(pclk), .presetn(presetn),
        .push(spi_tx_push), .push_data(spi_tx_data),
        .pop(tx_pop), .head(tx_head),
        .count(tx_byte_count), .full(), .empty(tx_empty),
        .overflow(), .underflow(tx_underflow)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pop_data <= 8'h00;
        end else if (tx_pop && !tx_empty) begin
            tx_pop_data <= tx_head;
        end
    end

    // ----------------------------------------
    // SPI pin synchronisers
    // ----------------------------------------
    logic [2:0] csn_s, sclk_s, mosi_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csn_s <= 3'h7;
            sclk_s <= 3'h0;
            mosi_s <= 3'h0;
        end else begin
            csn_s <= {csn_s[1:0], spi_csn_n};
            sclk_s <= {sclk_s[1:0], spi_sclk};
            mosi_s <= {mosi_s[1:0], spi_mosi};
        end
    end

    logic spi_active, spi_rise, spi_fall;
    assign spi_active = !csn_s[1];
    assign spi_rise = spi_active && sclk_s[1] && !sclk_s[2];
    assign spi_fall = spi_active && !sclk_s[1] && sclk_s[2];

    // ----------------------------------------
    // SPI frame engine
    // ----------------------------------------
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [6:0] shift_in, next_shift_in;
    logic [7:0] out_byte, next_out_byte, byte_in;
    logic first_byte, next_first_byte, is_read, next_is_read, is_fifo, next_is_fifo;
    logic next_miso, next_miso_oe;

    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_out_byte = out_byte;
        next_first_byte = first_byte;
        next_is_read = is_read;
        next_is_fifo = is_fifo;
        next_miso = spi_miso;
        next_miso_oe = spi_active;
        spi_rx_pop = 1'b0;
        spi_tx_push = 1'b0;
        byte_in = {shift_in, mosi_s[1]};
        spi_tx_data = byte_in;
        if (!spi_active) begin
            next_bit_cnt = 3'h0;
            next_first_byte = 1'b1;
            next_is_fifo = 1'b0;
            next_miso = 1'b0;
        end else if (spi_rise) begin
            next_bit_cnt = 3'(bit_cnt + 3'h1);
            next_shift_in = byte_in[6:0];
            if (first_byte && bit_cnt == 3'h0) begin
                next_is_read = mosi_s[1];
                // Status byte: fill level of the buffer the access uses
                next_out_byte = {1'b0, mosi_s[1] ? rx_byte_count : tx_byte_count};
            end
            if (bit_cnt == 3'h7) begin
                next_out_byte = 8'h00;
                if (first_byte) begin
                    next_first_byte = 1'b0;
                    next_is_fifo = (byte_in[5:0] == fifo_pair_pkg::FIFO_ADDR);
                end else if (is_fifo && is_read) begin
                    // Pop only the byte just shifted out, no prefetch loss
                    spi_rx_pop = 1'b1;
                end else if (is_fifo) begin
                    spi_tx_push = 1'b1;
                end
            end
        end else if (spi_fall) begin
            if (bit_cnt == 3'h0 && is_fifo && is_read) begin
                // Head taken after the previous pop has settled
                next_out_byte = rx_head;
                next_miso = rx_head[7];
            end else begin
                next_miso = out_byte[~bit_cnt];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 3'h0;
            shift_in <= 7'h00;
            out_byte <= 8'h00;
            first_byte <= 1'b1;
            is_read <= 1'b0;
            is_fifo <= 1'b0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            out_byte <= next_out_byte;
            first_byte <= next_first_byte;
            is_read <= next_is_read;
            is_fifo <= next_is_fifo;
            spi_miso <= next_miso;
            spi_miso_oe <= next_miso_oe;
        end
    end

    // ----------------------------------------
    // Thresholds
    // ----------------------------------------
    logic [3:0] buffer_threshold_select;
    logic [CW-1:0] rx_thr_bytes, tx_thr_bytes;
    logic rx_thr_level, tx_thr_level;

    assign rx_thr_bytes = CW'(({3'h0, buffer_threshold_select} + 7'h01) * 7'(fifo_pair_pkg::THR_STEP));
    assign tx_thr_bytes = CW'(7'(fifo_pair_pkg::TX_THR_BASE)
        - {3'h0, buffer_threshold_select} * 7'(fifo_pair_pkg::THR_STEP));

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [PINS-1:0][5:0] output_pin_signal_select, next_pin_sel;
    logic [3:0] next_thr_sel;
    logic [IW-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask, irq_events, w1c;
    logic [31:0] next_prdata, pin_sel_word;
    logic next_pslverr, next_rx_level, next_tx_level, wr_en, rd_setup;
    logic [PINS-1:0] next_pins;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign irq_events = {tx_underflow, rx_overflow};
    assign irq = |(irq_status & irq_mask);

    always_comb begin
        pin_sel_word = 32'h0000_0000;
        for (int i = 0; i < PINS; i++) begin
            pin_sel_word[i*fifo_pair_pkg::SEL_STRIDE +: fifo_pair_pkg::SEL_W] = output_pin_signal_select[i];
        end
    end

    always_comb begin
        next_thr_sel = buffer_threshold_select;
        next_pin_sel = output_pin_signal_select;
        next_irq_mask = irq_mask;
        w1c = '0;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (wr_en) begin
            case (paddr)
                fifo_pair_pkg::OFF_THR: next_thr_sel = pwdata[3:0];
                fifo_pair_pkg::OFF_PIN_SEL: begin
                    for (int i = 0; i < PINS; i++) begin
                        next_pin_sel[i] = pwdata[i*fifo_pair_pkg::SEL_STRIDE +: fifo_pair_pkg::SEL_W];
                    end
                end
                fifo_pair_pkg::OFF_IRQ_STATUS: w1c = pwdata[IW-1:0];
                fifo_pair_pkg::OFF_IRQ_MASK: next_irq_mask = pwdata[IW-1:0];
                default: begin
                end
            endcase
        end
        // Sticky events win over a same-cycle clear
        next_irq_status = (irq_status & ~w1c) | irq_events;
        if (rd_setup) begin
            next_pslverr = 1'b0;
            case (paddr)
                fifo_pair_pkg::OFF_THR: next_prdata = {28'h000_0000, buffer_threshold_select};
                fifo_pair_pkg::OFF_PIN_SEL: next_prdata = pin_sel_word;
                fifo_pair_pkg::OFF_RX_COUNT: next_prdata = {25'h000_0000, rx_byte_count};
                fifo_pair_pkg::OFF_TX_COUNT: next_prdata = {25'h000_0000, tx_byte_count};
                fifo_pair_pkg::OFF_IRQ_STATUS: next_prdata = {30'h0000_0000, irq_status};
                fifo_pair_pkg::OFF_IRQ_MASK: next_prdata = {30'h0000_0000, irq_mask};
                default: begin
                    next_prdata = 32'h0000_0000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        next_rx_level = (rx_byte_count >= rx_thr_bytes);
        next_tx_level = (tx_byte_count >= tx_thr_bytes);
        for (int i = 0; i < PINS; i++) begin
            case (output_pin_signal_select[i])
                fifo_pair_pkg::SEL_RX_THR: next_pins[i] = rx_thr_level;
                fifo_pair_pkg::SEL_TX_THR: next_pins[i] = tx_thr_level;
                default: next_pins[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_threshold_select <= fifo_pair_pkg::THR_RST;
            output_pin_signal_select <= {PINS{fifo_pair_pkg::PIN_SEL_RST}};
            irq_status <= '0;
            irq_mask <= fifo_pair_pkg::IRQ_MASK_RST;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            rx_thr_level <= 1'b0;
            tx_thr_level <= 1'b0;
            general_output_pin <= '0;
        end else begin
            buffer_threshold_select <= next_thr_sel;
            output_pin_signal_select <= next_pin_sel;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            rx_thr_level <= next_rx_level;
            tx_thr_level <= next_tx_level;
            general_output_pin <= next_pins;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_thr_sum_fixed: assert property (rx_thr_bytes + tx_thr_bytes == 7'(fifo_pair_pkg::THR_SUM))
        else $error("thresholds do not mirror each other");
    a_rx_thr_level: assert property ((rx_byte_count >= rx_thr_bytes) |=> rx_thr_level)
        else $error("receive threshold signal missing");
    a_tx_thr_drop: assert property ((tx_byte_count < tx_thr_bytes) |=> !tx_thr_level)
        else $error("transmit threshold signal stuck high");
    a_pin_rx_route: assert property ((output_pin_signal_select[0] == fifo_pair_pkg::SEL_RX_THR)
        ##1 (output_pin_signal_select[0] == fifo_pair_pkg::SEL_RX_THR) |-> general_output_pin[0] == $past(rx_thr_level))
        else $error("pin does not show receive threshold");
    a_overflow_sticky: assert property (rx_overflow |=> irq_status[fifo_pair_pkg::IRQ_RX_OVF]
        ##1 (irq_status[fifo_pair_pkg::IRQ_RX_OVF] || $past(w1c[fifo_pair_pkg::IRQ_RX_OVF])))
        else $error("overflow flag not set or lost");
    a_underflow_flag: assert property (tx_underflow |=> irq_status[fifo_pair_pkg::IRQ_TX_UNF])
        else $error("underflow flag not set");
    a_pop_once_byte: assert property (spi_rx_pop |=> !spi_rx_pop [*8])
        else $error("more than one pop per byte");
    a_status_byte: assert property ((spi_rise && first_byte && bit_cnt == 3'h0)
        |=> out_byte == {1'b0, $past(mosi_s[1]) ? $past(rx_byte_count) : $past(tx_byte_count)})
        else $error("status byte carries wrong fill level");
    a_count_read: assert property ((rd_setup && paddr == fifo_pair_pkg::OFF_RX_COUNT)
        |=> prdata == {25'h000_0000, $past(rx_byte_count)} && !pslverr)
        else $error("receive count read wrong");

    c_rx_pop: cover property (spi_rx_pop ##[1:400] spi_rx_pop);
    c_tx_push: cover property (spi_tx_push);
    c_overflow: cover property (rx_overflow);
    c_irq: cover property ($rose(irq));
endmodule

// ===== testbench/spi_host_model.sv
// SPI host model: mode 0 master on the block's serial port.
// Assumes pclk at 200 MHz; serial clock period 130 ns (26 pclk cycles).
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input wire logic pclk,
    // Serial pins
    output logic spi_csn_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    // Undriven return line reads as high impedance
    wire miso_line = spi_miso_oe ? spi_miso : 1'bz;
    logic [7:0] rd [64];

    initial begin
        spi_csn_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end

    // One byte, MSB first; clock idles low
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge pclk);
            spi_mosi <= tx[i];
            repeat (12) @(posedge pclk);
            rx[i] = miso_line;
            spi_sclk <= 1'b1;
            repeat (13) @(posedge pclk);
            spi_sclk <= 1'b0;
        end
    endtask

    // Header, then n data bytes valued base, base+1, ...
    task automatic frame(input logic [7:0] hdr, input int n, input logic [7:0] base, output logic [7:0] status);
        @(posedge pclk);
        spi_csn_n <= 1'b0;
        xfer(hdr, status);
        for (int i = 0; i < n; i++) begin
            xfer(base + 8'(i), rd[i]);
        end
        repeat (12) @(posedge pclk);
        spi_csn_n <= 1'b1;
        // Released data line shows no stale level
        spi_mosi <= ~spi_mosi;
        repeat (12) @(posedge pclk);
    endtask
endmodule

// ===== testbench/tb_radio_data_fifo_pair.sv
// Bench for the data buffer pair: APB registers, SPI host model, packet engine.
// Assumes spi_host_model; assertions live in the design files.
`timescale 1ns/1ps
module tb_radio_data_fifo_pair;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic spi_csn_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
    logic rx_push, tx_pop, irq;
    logic [7:0] rx_push_data, tx_pop_data, st;
    logic [2:0] general_output_pin;
    logic [7:0] tx_exp [$];
    int error_cnt, checked, cycles, rx_n, tx_n;

    radio_data_fifo_pair dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spi_csn_n(spi_csn_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .rx_push(rx_push),
        .rx_push_data(rx_push_data), .tx_pop(tx_pop), .tx_pop_data(tx_pop_data),
        .general_output_pin(general_output_pin), .irq(irq));
    spi_host_model host (.pclk(pclk), .spi_csn_n(spi_csn_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, exp, rdata);
    endtask

    task automatic push(input logic [7:0] d);
        @(posedge pclk);
        rx_push <= 1'b1;
        rx_push_data <= d;
        @(posedge pclk);
        rx_push <= 1'b0;
    endtask

    task automatic pop();
        @(posedge pclk);
        tx_pop <= 1'b1;
        @(posedge pclk);
        tx_pop <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pins_chk(input logic [2:0] e);
        repeat (4) @(posedge pclk);
        check("pins", 32'(e), 32'(general_output_pin));
    endtask

    task automatic irq_chk(input logic e);
        @(posedge pclk);
        check("irq", 32'(e), 32'(irq));
    endtask

    // Host writes n bytes; full buffer is never written
    task automatic wr_tx(input int n);
        logic [7:0] base;
        base = 8'(tx_n) + 8'h40;
        if (n > 0) begin
            host.frame(8'h7F, n, base, st);
            check("tx status", 32'(tx_n), 32'(st));
            for (int i = 0; i < n; i++) tx_exp.push_back(base + 8'(i));
            tx_n += n;
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        reg_chk("rx count", fifo_pair_pkg::OFF_RX_COUNT, 32'h0000_0000);
        reg_chk("tx count", fifo_pair_pkg::OFF_TX_COUNT, 32'h0000_0000);
        reg_chk("irq status", fifo_pair_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
        reg_chk("thr", fifo_pair_pkg::OFF_THR, 32'(fifo_pair_pkg::THR_RST));
        reg_chk("unmapped", 12'h020, 32'h0000_0000);
        check("pslverr", 32'h0000_0001, 32'(perr));
        pins_chk(3'b000);
        irq_chk(1'b0);
    endtask

    task automatic t_rx_thr();
        apb(1'b1, fifo_pair_pkg::OFF_PIN_SEL, 32'h0001_0200);
        for (int v = 0; v < 16; v++) begin
            while (rx_n < 4 * v + 3) begin
                push(8'(rx_n));
                rx_n++;
            end
            apb(1'b1, fifo_pair_pkg::OFF_THR, 32'(v));
            pins_chk(3'b000);
            push(8'(rx_n));
            rx_n++;
            pins_chk(3'b001);
        end
        reg_chk("rx count", fifo_pair_pkg::OFF_RX_COUNT, 32'd64);
    endtask

    task automatic t_rx_ovf();
        push(8'hEE);
        reg_chk("irq status", fifo_pair_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
        irq_chk(1'b0);
        apb(1'b1, fifo_pair_pkg::OFF_IRQ_MASK, 32'h0000_0003);
        irq_chk(1'b1);
        apb(1'b1, fifo_pair_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
        irq_chk(1'b0);
        reg_chk("rx count", fifo_pair_pkg::OFF_RX_COUNT, 32'd64);
    endtask

    // Whole packet waiting; reads fewer than held, never to empty
    task automatic t_rx_read();
        reg_chk("rx poll", fifo_pair_pkg::OFF_RX_COUNT, 32'd64);
        reg_chk("rx poll", fifo_pair_pkg::OFF_RX_COUNT, 32'd64);
        host.frame(8'hFF, 3, 8'h00, st);
        check("rx status", 32'd64, 32'(st));
        for (int i = 0; i < 3; i++) check("rx data", 32'(i), 32'(host.rd[i]));
        reg_chk("rx count", fifo_pair_pkg::OFF_RX_COUNT, 32'd61);
    endtask

    task automatic t_tx_thr();
        // Header for another address: data bytes must not reach the buffer
        host.frame(8'h3E, 1, 8'h55, st);
        check("tx status", 32'h0000_0000, 32'(st));
        reg_chk("tx count", fifo_pair_pkg::OFF_TX_COUNT, 32'h0000_0000);
        for (int v = 15; v >= 0; v--) begin
            wr_tx(60 - 4 * v - tx_n);
            apb(1'b1, fifo_pair_pkg::OFF_THR, 32'(v));
            pins_chk({2'b00, 1'(v < 15)});
            wr_tx(1);
            pins_chk({2'b01, 1'(v < 15)});
        end
        wr_tx(3);
        reg_chk("tx count", fifo_pair_pkg::OFF_TX_COUNT, 32'd64);
    endtask

    task automatic t_tx_drain();
        while (tx_exp.size() > 0) begin
            pop();
            check("tx data", 32'(tx_exp.pop_front()), 32'(tx_pop_data));
        end
        reg_chk("tx count", fifo_pair_pkg::OFF_TX_COUNT, 32'd0);
        pop();
        reg_chk("irq status", fifo_pair_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
        irq_chk(1'b1);
        apb(1'b1, fifo_pair_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
        irq_chk(1'b0);
    endtask

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, rx_push, tx_pop} = 5'b00000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rx_push_data = 8'h00;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_rx_thr();
        t_rx_ovf();
        t_rx_read();
        t_tx_thr();
        t_tx_drain();
        final_report();
    end
endmodule
